//--- sclp_defines.vh
`ifndef SCLP_DEFINES_VH
`define SCLP_DEFINES_VH

// register word addresses (avalon word index, 4-byte spacing)
`define SCLP_ADR_W 4
`define SCLP_ADR_CFG_A 4'h0
`define SCLP_ADR_CFG_B 4'h1
`define SCLP_ADR_LINE 4'h2
`define SCLP_ADR_IRQ_STAT 4'h3
`define SCLP_ADR_IRQ_EN 4'h4
`define SCLP_ADR_IRQ_CLR 4'h5

// per-channel configuration register fields
`define SCLP_CFG_W 13
`define SCLP_CFG_RESET 13'h0000
`define SCLP_F_RTS_SW 0
`define SCLP_F_PIN_SWAP 1
`define SCLP_F_OPEN_DRAIN 2
`define SCLP_F_NRZI_IDLE 3
`define SCLP_F_AUTO_START 4
`define SCLP_F_CTS_IRQ 5
`define SCLP_F_CD_IRQ 6
`define SCLP_F_BUS_MODE 7
`define SCLP_F_CMODE_LO 8
`define SCLP_F_CMODE_HI 10
`define SCLP_F_BUSRTS_LO 11
`define SCLP_F_BUSRTS_HI 12

// bus rts options in bus configuration
`define SCLP_BRTS_W 2
`define SCLP_BRTS_TX 2'h0
`define SCLP_BRTS_RX 2'h1
`define SCLP_BRTS_OFF 2'h2

// clock modes
`define SCLP_CM_W 3
`define SCLP_CM_0 3'h0
`define SCLP_CM_1 3'h1
`define SCLP_CM_2 3'h2
`define SCLP_CM_3 3'h3
`define SCLP_CM_5 3'h5

// interrupt status bits: per channel cts then cd
`define SCLP_IRQ_W 4
`define SCLP_IRQ_RESET 4'h0

// receive clock pin roles
`define SCLP_RCR_W 2
`define SCLP_RCR_RX 2'h0
`define SCLP_RCR_RXTX 2'h1
`define SCLP_RCR_BRG 2'h2
`define SCLP_RCR_NONE 2'h3

// carrier detect pin roles
`define SCLP_CDR_W 2
`define SCLP_CDR_MODEM 2'h0
`define SCLP_CDR_RXEN 2'h1
`define SCLP_CDR_STROBE 2'h2
`define SCLP_CDR_FSYNC 2'h3

`define SCLP_ZERO32 32'h00000000
`endif

//--- sclp_chan.v
`timescale 1ns/10ps
`include "sclp_defines.vh"

module sclp_chan (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // configuration
    input wire [12:0] cfg_in,
    // synchronised pins
    input wire rxd_pin_in,
    input wire txd_pin_in,
    input wire cts_n_in,
    input wire cd_in,
    input wire coll_in,
    // core side
    input wire tx_data_in,
    input wire tx_active_in,
    input wire tx_pending_in,
    input wire rx_frame_in,
    // results
    output reg rx_data_out,
    output reg txd_o_out,
    output reg txd_oe_n_out,
    output reg rxd_o_out,
    output reg rxd_oe_n_out,
    output reg rts_n_out,
    output reg tx_enable_out,
    output reg collision_out,
    output reg [1:0] rclk_role_out,
    output reg [1:0] cd_role_out,
    output reg cts_evt_out,
    output reg cd_evt_out
);

    reg cts_prev_ff;
    reg cd_prev_ff;
    reg tx_act_d_ff;
    reg rts_idle_ff;
    reg nxt_rts_n;
    reg nxt_line;
    reg drive_bit;

    wire [2:0] cmode = cfg_in[`SCLP_F_CMODE_HI:`SCLP_F_CMODE_LO];
    wire [1:0] brts = cfg_in[`SCLP_F_BUSRTS_HI:`SCLP_F_BUSRTS_LO];
    wire bus_mode = cfg_in[`SCLP_F_BUS_MODE];
    wire swap = cfg_in[`SCLP_F_PIN_SWAP];

    // bus-mode rts (tx option) follows transmission delayed one clock, not during collision
    always @* begin
        if (cfg_in[`SCLP_F_RTS_SW]) begin
            nxt_rts_n = 1'b0;
        end else if (bus_mode) begin
            case (brts)
                `SCLP_BRTS_TX: nxt_rts_n = ~(tx_act_d_ff & ~collision_out);
                `SCLP_BRTS_RX: nxt_rts_n = ~rx_frame_in;
                default: nxt_rts_n = 1'b1;
            endcase
        end else begin
            nxt_rts_n = ~rts_idle_ff;
        end
        // idle nrzi fill: tx line ored with rts
        nxt_line = tx_data_in;
        if (cfg_in[`SCLP_F_NRZI_IDLE] && !cfg_in[`SCLP_F_RTS_SW]) begin
            nxt_line = tx_data_in | nxt_rts_n;
        end
        // open drain drives only zeros; push-pull drives always
        drive_bit = ~(cfg_in[`SCLP_F_OPEN_DRAIN] & nxt_line);
    end

    // transmit line drive and pin swap
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cts_prev_ff <= 1'b1;
            cd_prev_ff <= 1'b1; // matches synchroniser reset, no false edge
            tx_act_d_ff <= 1'b0;
            rts_idle_ff <= 1'b0;
            rts_n_out <= 1'b1;
            txd_o_out <= 1'b1;
            txd_oe_n_out <= 1'b1;
            rxd_o_out <= 1'b1;
            rxd_oe_n_out <= 1'b1;
            rx_data_out <= 1'b1;
            tx_enable_out <= 1'b0;
            collision_out <= 1'b0;
            rclk_role_out <= `SCLP_RCR_RX;
            cd_role_out <= `SCLP_CDR_MODEM;
            cts_evt_out <= 1'b0;
            cd_evt_out <= 1'b0;
        end else begin
            tx_act_d_ff <= tx_active_in;
            // rts stays low while transmitter busy or more is queued
            rts_idle_ff <= tx_active_in | tx_pending_in;
            rts_n_out <= nxt_rts_n;
            tx_enable_out <= ~cts_n_in;
            // collision: bus level differs from a driven bit
            collision_out <= bus_mode & tx_active_in & (coll_in != tx_data_in);
            if (swap) begin
                txd_oe_n_out <= 1'b1;
                rxd_o_out <= nxt_line;
                rxd_oe_n_out <= ~drive_bit;
                rx_data_out <= txd_pin_in;
                txd_o_out <= 1'b1;
            end else begin
                txd_o_out <= nxt_line;
                txd_oe_n_out <= ~drive_bit;
                rxd_o_out <= 1'b1;
                rxd_oe_n_out <= 1'b1;
                rx_data_out <= rxd_pin_in;
            end
            // receive clock pin role by clock mode
            case (cmode)
                `SCLP_CM_0: rclk_role_out <= `SCLP_RCR_RX;
                `SCLP_CM_1, `SCLP_CM_5: rclk_role_out <= `SCLP_RCR_RXTX;
                `SCLP_CM_2, `SCLP_CM_3: rclk_role_out <= `SCLP_RCR_BRG;
                default: rclk_role_out <= `SCLP_RCR_NONE;
            endcase
            // carrier detect role
            if (!cfg_in[`SCLP_F_AUTO_START]) begin
                cd_role_out <= `SCLP_CDR_MODEM;
            end else begin
                case (cmode)
                    `SCLP_CM_1: cd_role_out <= `SCLP_CDR_STROBE;
                    `SCLP_CM_5: cd_role_out <= `SCLP_CDR_FSYNC;
                    default: cd_role_out <= `SCLP_CDR_RXEN;
                endcase
            end
            // transition detectors
            cts_prev_ff <= cts_n_in;
            cd_prev_ff <= cd_in;
            cts_evt_out <= cfg_in[`SCLP_F_CTS_IRQ] & (cts_prev_ff != cts_n_in);
            cd_evt_out <= cfg_in[`SCLP_F_CD_IRQ] & (cd_prev_ff != cd_in);
        end
    end

endmodule

//--- sclp_top.v
`timescale 1ns/10ps
`include "sclp_defines.vh"

module sclp_top (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // avalon-mm slave
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    output reg irq_out,
    // line pins channel a and b (index 0 = a)
    input wire [1:0] rxd_pin_in,
    output reg [1:0] rxd_pin_out,
    output reg [1:0] rxd_pin_oe_n_out,
    input wire [1:0] receive_clock_pin_in,
    output reg [1:0] rts_n_out,
    input wire [1:0] cts_n_in,
    input wire [1:0] cd_in,
    input wire [1:0] txd_pin_in,
    output reg [1:0] txd_pin_out,
    output reg [1:0] txd_pin_oe_n_out,
    // serial core side per channel
    input wire [1:0] tx_data_in,
    input wire [1:0] tx_active_in,
    input wire [1:0] tx_pending_in,
    input wire [1:0] rx_frame_in,
    output reg [1:0] rx_data_out,
    output reg [1:0] rx_clock_out,
    output reg [1:0] tx_enable_out,
    output reg [1:0] collision_out,
    output reg [3:0] rclk_role_out,
    output reg [3:0] cd_role_out
);

    reg [12:0] cfg_a_ff;
    reg [12:0] cfg_b_ff;
    reg [3:0] irq_stat_ff;
    reg [3:0] irq_en_ff;
    reg [9:0] sync1_ff;
    reg [9:0] sync2_ff;
    reg ack_ff;
    reg [31:0] nxt_rdata;

    wire [1:0] c_rx;
    wire [1:0] c_txo;
    wire [1:0] c_txoe;
    wire [1:0] c_rxo;
    wire [1:0] c_rxoe;
    wire [1:0] c_rts;
    wire [1:0] c_txen;
    wire [1:0] c_coll;
    wire [3:0] c_rcr;
    wire [3:0] c_cdr;
    wire [3:0] c_evt;
    wire [3:0] irq_set;

    // all pin inputs pass two flip-flops; first stage read by second only
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_ff <= 10'h3ff;
            sync2_ff <= 10'h3ff;
        end else begin
            sync1_ff <= {receive_clock_pin_in, txd_pin_in, cd_in, cts_n_in, rxd_pin_in};
            sync2_ff <= sync1_ff;
        end
    end

    // two independent channel instances
    sclp_chan u_chan_a (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .cfg_in(cfg_a_ff),
        .rxd_pin_in(sync2_ff[0]),
        .txd_pin_in(sync2_ff[6]),
        .cts_n_in(sync2_ff[2]),
        .cd_in(sync2_ff[4]),
        .coll_in(sync2_ff[2]),
        .tx_data_in(tx_data_in[0]),
        .tx_active_in(tx_active_in[0] & ~sync2_ff[2]),
        .tx_pending_in(tx_pending_in[0]),
        .rx_frame_in(rx_frame_in[0]),
        .rx_data_out(c_rx[0]),
        .txd_o_out(c_txo[0]),
        .txd_oe_n_out(c_txoe[0]),
        .rxd_o_out(c_rxo[0]),
        .rxd_oe_n_out(c_rxoe[0]),
        .rts_n_out(c_rts[0]),
        .tx_enable_out(c_txen[0]),
        .collision_out(c_coll[0]),
        .rclk_role_out(c_rcr[1:0]),
        .cd_role_out(c_cdr[1:0]),
        .cts_evt_out(c_evt[0]),
        .cd_evt_out(c_evt[1])
    );

    sclp_chan u_chan_b (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .cfg_in(cfg_b_ff),
        .rxd_pin_in(sync2_ff[1]),
        .txd_pin_in(sync2_ff[7]),
        .cts_n_in(sync2_ff[3]),
        .cd_in(sync2_ff[5]),
        .coll_in(sync2_ff[3]),
        .tx_data_in(tx_data_in[1]),
        .tx_active_in(tx_active_in[1] & ~sync2_ff[3]),
        .tx_pending_in(tx_pending_in[1]),
        .rx_frame_in(rx_frame_in[1]),
        .rx_data_out(c_rx[1]),
        .txd_o_out(c_txo[1]),
        .txd_oe_n_out(c_txoe[1]),
        .rxd_o_out(c_rxo[1]),
        .rxd_oe_n_out(c_rxoe[1]),
        .rts_n_out(c_rts[1]),
        .tx_enable_out(c_txen[1]),
        .collision_out(c_coll[1]),
        .rclk_role_out(c_rcr[3:2]),
        .cd_role_out(c_cdr[3:2]),
        .cts_evt_out(c_evt[2]),
        .cd_evt_out(c_evt[3])
    );

    // status bit order: a cts, a cd, b cts, b cd
    assign irq_set = c_evt;

    // read mux; unmapped addresses read zero
    always @* begin
        nxt_rdata = `SCLP_ZERO32;
        case (avs_address_in)
            `SCLP_ADR_CFG_A: nxt_rdata = {19'h00000, cfg_a_ff};
            `SCLP_ADR_CFG_B: nxt_rdata = {19'h00000, cfg_b_ff};
            `SCLP_ADR_LINE: nxt_rdata = {22'h000000, sync2_ff};
            `SCLP_ADR_IRQ_STAT: nxt_rdata = {28'h0000000, irq_stat_ff};
            `SCLP_ADR_IRQ_EN: nxt_rdata = {28'h0000000, irq_en_ff};
            default: nxt_rdata = `SCLP_ZERO32;
        endcase
    end

    // one wait cycle per access: waitrequest drops the cycle after the request
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ack_ff <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= `SCLP_ZERO32;
            cfg_a_ff <= `SCLP_CFG_RESET;
            cfg_b_ff <= `SCLP_CFG_RESET;
            irq_en_ff <= `SCLP_IRQ_RESET;
            irq_stat_ff <= `SCLP_IRQ_RESET;
            irq_out <= 1'b0;
        end else begin
            ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
            avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_ff);
            if (avs_read_in && !ack_ff) begin
                avs_readdata_out <= nxt_rdata;
            end
            if (avs_write_in && ack_ff) begin
                case (avs_address_in)
                    `SCLP_ADR_CFG_A: cfg_a_ff <= avs_writedata_in[12:0];
                    `SCLP_ADR_CFG_B: cfg_b_ff <= avs_writedata_in[12:0];
                    `SCLP_ADR_IRQ_EN: irq_en_ff <= avs_writedata_in[3:0];
                    default: ;
                endcase
            end
            // set wins over a simultaneous clear
            if (avs_write_in && ack_ff && avs_address_in == `SCLP_ADR_IRQ_CLR) begin
                irq_stat_ff <= (irq_stat_ff & ~avs_writedata_in[3:0]) | irq_set;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
            irq_out <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // registered pin and core outputs
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            rxd_pin_out <= 2'h3;
            rxd_pin_oe_n_out <= 2'h3;
            rts_n_out <= 2'h3;
            txd_pin_out <= 2'h3;
            txd_pin_oe_n_out <= 2'h3;
            rx_data_out <= 2'h3;
            rx_clock_out <= 2'h0;
            tx_enable_out <= 2'h0;
            collision_out <= 2'h0;
            rclk_role_out <= 4'h0;
            cd_role_out <= 4'h0;
        end else begin
            rxd_pin_out <= c_rxo;
            rxd_pin_oe_n_out <= c_rxoe;
            rts_n_out <= c_rts;
            txd_pin_out <= c_txo;
            txd_pin_oe_n_out <= c_txoe;
            rx_data_out <= c_rx;
            rx_clock_out <= sync2_ff[9:8];
            tx_enable_out <= c_txen;
            collision_out <= c_coll;
            rclk_role_out <= c_rcr;
            cd_role_out <= c_cdr;
        end
    end

endmodule

//--- sclp_properties.sv
`timescale 1ns/10ps
`include "sclp_defines.vh"

module sclp_props (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // register bus
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire avs_waitrequest_out,
    // line pins
    input wire [1:0] cts_n_in,
    input wire [1:0] rts_n_out,
    input wire [1:0] txd_pin_out,
    input wire [1:0] txd_pin_oe_n_out,
    input wire [1:0] tx_enable_out,
    input wire [3:0] rclk_role_out,
    input wire [3:0] cd_role_out
);
    reg [12:0] cfg_ff;
    reg [3:0] age_ff;
    wire [2:0] cm = cfg_ff[10:8];
    wire ok = age_ff > 4'h5;
    wire wr_done = avs_write_in && !avs_waitrequest_out;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    // mirror of channel a config; outputs trail a write by a few edges
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_ff <= 13'h0000;
            age_ff <= 4'h0;
        end else begin
            if (wr_done && avs_address_in == `SCLP_ADR_CFG_A) begin
                cfg_ff <= avs_writedata_in[12:0];
            end
            age_ff <= wr_done ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
        end
    end

    function [1:0] rexp(input [2:0] m);
        rexp = (m == 3'h0) ? `SCLP_RCR_RX : (m == 3'h1 || m == 3'h5) ? `SCLP_RCR_RXTX : `SCLP_RCR_BRG;
    endfunction

    function [1:0] cexp(input [2:0] m, input a);
        cexp = !a ? `SCLP_CDR_MODEM : (m == 3'h1) ? `SCLP_CDR_STROBE :
            (m == 3'h5) ? `SCLP_CDR_FSYNC : `SCLP_CDR_RXEN;
    endfunction

    sequence s_taken;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_one_ack;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence

    AST_BUS_ONE_WAIT: assert property (s_taken |=> s_one_ack)
        else $error("bus answer not a single wait cycle");
    AST_TX_ENABLE: assert property ($stable(cts_n_in[0]) [*6] |-> tx_enable_out[0] == !cts_n_in[0])
        else $error("transmit enable does not follow clear to send");
    AST_RTS_SW: assert property (ok && cfg_ff[0] && !cfg_ff[7] |-> !rts_n_out[0])
        else $error("rts high while software bit set");
    AST_OD_ZERO: assert property (ok && cfg_ff[2] && !cfg_ff[1] && !txd_pin_oe_n_out[0] |-> !txd_pin_out[0])
        else $error("open drain pin driven high");
    AST_PP_DRIVE: assert property (ok && !cfg_ff[2] && !cfg_ff[1] |-> !txd_pin_oe_n_out[0])
        else $error("push pull pin not driven");
    AST_SWAP_REL: assert property (ok && cfg_ff[1] |-> txd_pin_oe_n_out[0])
        else $error("swapped transmit pin still driven");
    AST_RCLK_ROLE: assert property (ok && (cm < 3'h4 || cm == 3'h5) |-> rclk_role_out[1:0] == rexp(cm))
        else $error("receive clock role wrong");
    AST_CD_ROLE: assert property (ok && (cfg_ff[4] || (cm != 3'h1 && cm != 3'h5)) |->
        cd_role_out[1:0] == cexp(cm, cfg_ff[4]))
        else $error("carrier detect role wrong");
endmodule

bind sclp_top sclp_props u_props (.clk_sys_in, .reset_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .cts_n_in, .rts_n_out, .txd_pin_out,
    .txd_pin_oe_n_out, .tx_enable_out, .rclk_role_out, .cd_role_out);

//--- sclp_line_model.sv
`timescale 1ns/10ps

module sclp_line_model (
    // clock and design pins, oe_n low = design drives
    input wire clk_in,
    input wire [1:0] tdrv_in,
    input wire [1:0] toe_n_in,
    input wire [1:0] rdrv_in,
    input wire [1:0] roe_n_in,
    // far side commands
    input wire run_in,
    input wire [1:0] cts_in,
    input wire [1:0] cd_in,
    input wire [1:0] fb_in,
    input wire [1:0] fen_in,
    input wire [1:0] bus_in,
    input wire [1:0] jam_in,
    // resolved lines
    output wire [1:0] cts_n_out,
    output wire [1:0] cd_out,
    output wire [1:0] txd_out,
    output wire [1:0] rxd_out,
    output reg [1:0] rclk_out
);
    // pull-ups keep a released pin from echoing stale data
    assign txd_out = (~toe_n_in & tdrv_in) | (toe_n_in & (~fen_in | fb_in));
    assign rxd_out = (~roe_n_in & rdrv_in) | (roe_n_in & (fen_in | fb_in));
    // shared bus on the collision input; a jam pulls it low
    assign cts_n_out = (bus_in & txd_out & ~jam_in) | (~bus_in & cts_in);
    assign cd_out = cd_in;
    // line clock stands still outside frames
    initial rclk_out = 2'h0;
    always @(posedge clk_in) begin
        if (run_in) begin
            rclk_out <= ~rclk_out;
        end
    end
endmodule

//--- sclp_tb_top.sv
`timescale 1ns/10ps
`include "sclp_defines.vh"
`define CHK(nm, ex, got) begin checks = checks + 1; if ((got) !== (ex)) begin \
n_errors = n_errors + 1; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module sclp_tb_top;
    reg clk_sys_in = 1'b0;
    reg reset_in = 1'b1;
    reg rd = 1'b0, wr = 1'b0, run = 1'b0;
    reg [3:0] adr = 4'h0;
    reg [31:0] wd = 32'h0, rv;
    reg [1:0] txd = 2'h0, act = 2'h0, pend = 2'h0, rxf = 2'h0, cts = 2'h0, cd = 2'h0;
    reg [1:0] fb = 2'h0, fen = 2'h0, bus = 2'h0, jam = 2'h0;
    reg [7:0] lfsr = 8'h12;
    integer n_errors = 0, checks = 0, cycles = 0, i;
    wire [31:0] rdat;
    wire wreq, irq;
    wire [1:0] rxo, rxoe, rts, txo, txoe, rxd_d, ten, coll, cts_w, cd_w, txd_w, rxd_w, rclk;
    wire [3:0] rrole, crole;
    wire [1:0] rxc;

    sclp_top uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .irq_out(irq), .rxd_pin_in(rxd_w), .rxd_pin_out(rxo),
        .rxd_pin_oe_n_out(rxoe), .receive_clock_pin_in(rclk), .rts_n_out(rts), .cts_n_in(cts_w),
        .cd_in(cd_w), .txd_pin_in(txd_w), .txd_pin_out(txo), .txd_pin_oe_n_out(txoe),
        .tx_data_in(txd), .tx_active_in(act), .tx_pending_in(pend), .rx_frame_in(rxf),
        .rx_data_out(rxd_d), .rx_clock_out(rxc), .tx_enable_out(ten), .collision_out(coll),
        .rclk_role_out(rrole), .cd_role_out(crole));
    sclp_line_model u_line (.clk_in(clk_sys_in), .tdrv_in(txo), .toe_n_in(txoe), .rdrv_in(rxo),
        .roe_n_in(rxoe), .run_in(run), .cts_in(cts), .cd_in(cd), .fb_in(fb), .fen_in(fen),
        .bus_in(bus), .jam_in(jam), .cts_n_out(cts_w), .cd_out(cd_w), .txd_out(txd_w),
        .rxd_out(rxd_w), .rclk_out(rclk));

    initial begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    function [7:0] nxt(input [7:0] s);
        nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function [1:0] rexp(input [2:0] m);
        rexp = (m == 3'h0) ? `SCLP_RCR_RX : (m == 3'h1 || m == 3'h5) ? `SCLP_RCR_RXTX :
            (m == 3'h2 || m == 3'h3) ? `SCLP_RCR_BRG : `SCLP_RCR_NONE;
    endfunction
    function [1:0] cexp(input [2:0] m, input a);
        cexp = !a ? `SCLP_CDR_MODEM : (m == 3'h1) ? `SCLP_CDR_STROBE :
            (m == 3'h5) ? `SCLP_CDR_FSYNC : `SCLP_CDR_RXEN;
    endfunction

    // one bus cycle; request held until waitrequest is seen low, only the hang guard ends a wait
    task xfer(input is_rd, input [3:0] a, input [31:0] d, output [31:0] q);
        begin
            adr <= a;
            wd <= d;
            rd <= is_rd;
            wr <= !is_rd;
            @(posedge clk_sys_in);
            while (wreq !== 1'b0) begin
                @(posedge clk_sys_in);
            end
            q = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge clk_sys_in);
        end
    endtask

    task settle;
        repeat (6) @(posedge clk_sys_in);
    endtask

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_in) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            tally_and_finish;
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
        `CHK("rts_reset", 2'h3, rts)
        xfer(1, 4'hf, 32'h0, rv);
        `CHK("unmapped", 32'h0, rv)
        // clock mode table with random auto-start
        run <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = nxt(lfsr);
            xfer(0, `SCLP_ADR_CFG_A, {21'h0, i[2:0], 3'h0, lfsr[0], 4'h0}, rv);
            settle;
            `CHK("rclk_role", rexp(i[2:0]), rrole[1:0])
            // free-running pin toggles each edge; three stages of delay invert it
            `CHK("rx_clock", ~rclk, rxc)
            if (lfsr[0] || (i != 1 && i != 5)) `CHK("cd_role", cexp(i[2:0], lfsr[0]), crole[1:0])
        end
        `CHK("b_rclk_role", `SCLP_RCR_RX, rrole[3:2])
        `CHK("b_cd_role", `SCLP_CDR_MODEM, crole[3:2])
        run <= 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            lfsr = nxt(lfsr);
            cts <= lfsr[1:0];
            settle;
            `CHK("tx_enable", ~lfsr[1:0], ten)
        end
        cts <= 2'h0;
        xfer(0, `SCLP_ADR_CFG_A, 32'h1, rv);
        settle;
        `CHK("rts_sw", 2'h2, rts)
        act <= 2'h1;
        xfer(0, `SCLP_ADR_CFG_A, 32'h0, rv);
        settle;
        `CHK("rts_busy", 2'h2, rts)
        act <= 2'h0;
        pend <= 2'h1;
        settle;
        `CHK("rts_pend", 2'h2, rts)
        pend <= 2'h0;
        xfer(0, `SCLP_ADR_CFG_A, 32'h8, rv);
        settle;
        `CHK("rts_idle", 2'h3, rts)
        `CHK("txd_or_rts", 1'b1, txo[0])
        // bus configuration: transmit, collision, receive, disabled
        bus <= 2'h1;
        act <= 2'h1;
        xfer(0, `SCLP_ADR_CFG_A, 32'h80, rv);
        settle;
        `CHK("bus_rts_tx", 1'b0, rts[0])
        `CHK("no_coll", 1'b0, coll[0])
        txd <= 2'h1;
        jam <= 2'h1;
        settle;
        `CHK("coll", 1'b1, coll[0])
        `CHK("bus_rts_coll", 1'b1, rts[0])
        jam <= 2'h0;
        txd <= 2'h0;
        act <= 2'h0;
        rxf <= 2'h1;
        xfer(0, `SCLP_ADR_CFG_A, 32'h880, rv);
        settle;
        `CHK("bus_rts_rx", 1'b0, rts[0])
        rxf <= 2'h0;
        act <= 2'h1;
        xfer(0, `SCLP_ADR_CFG_A, 32'h1080, rv);
        settle;
        `CHK("bus_rts_off", 1'b1, rts[0])
        act <= 2'h0;
        bus <= 2'h0;
        // driver kind and pin swap with random line data
        for (i = 0; i < 4; i = i + 1) begin
            lfsr = nxt(lfsr);
            txd <= lfsr[1:0];
            fb <= lfsr[3:2];
            fen <= {2{i[0]}};
            xfer(0, `SCLP_ADR_CFG_A, {29'h0, i[1:0], 1'b0}, rv);
            xfer(0, `SCLP_ADR_CFG_B, {29'h0, i[1:0], 1'b0}, rv);
            settle;
            if (i[0]) begin
                `CHK("txd_released", 2'h3, txoe)
                `CHK("rx_from_txd", lfsr[3:2], rxd_d)
                `CHK("rxd_pin_tx", lfsr[1:0], rxd_w)
                `CHK("rxd_oe", i[1] ? lfsr[1:0] : 2'h0, rxoe)
            end else begin
                `CHK("txd_level", lfsr[1:0], txd_w)
                `CHK("txd_oe", i[1] ? lfsr[1:0] : 2'h0, txoe)
                `CHK("rx_data", lfsr[3:2], rxd_d)
                `CHK("rxd_released", 2'h3, rxoe)
            end
        end
        // transition interrupts: a cts on a, cd on b only
        xfer(0, `SCLP_ADR_CFG_A, 32'h20, rv);
        xfer(0, `SCLP_ADR_CFG_B, 32'h40, rv);
        xfer(0, `SCLP_ADR_IRQ_EN, 32'h1, rv);
        xfer(0, `SCLP_ADR_IRQ_CLR, 32'hf, rv);
        cts <= 2'h1;
        cd <= 2'h3;
        settle;
        xfer(1, `SCLP_ADR_IRQ_STAT, 32'h0, rv);
        `CHK("irq_stat", 32'h9, rv)
        `CHK("irq_on", 1'b1, irq)
        xfer(0, `SCLP_ADR_IRQ_CLR, 32'h1, rv);
        settle;
        `CHK("irq_masked", 1'b0, irq)
        xfer(0, `SCLP_ADR_IRQ_EN, 32'h8, rv);
        settle;
        `CHK("irq_b", 1'b1, irq)
        xfer(0, `SCLP_ADR_IRQ_CLR, 32'h8, rv);
        xfer(1, `SCLP_ADR_IRQ_STAT, 32'h0, rv);
        `CHK("irq_clr", 32'h0, rv)
        // second reset in mid-run: configuration and rts back to idle
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
        `CHK("rst_rts", 2'h3, rts)
        xfer(1, `SCLP_ADR_CFG_A, 32'h0, rv);
        `CHK("rst_cfg", 32'h0, rv)
        tally_and_finish;
    end
endmodule
